/* design/psdsb_bank.sv */
`timescale 1ns/1ns
module psdsb_bank
	import psdsb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Fault event pulses, one per stage, same clock domain
	input wire logic [PSDSB_NSTAGE-1:0] stage_short_to_ground,
	input wire logic [PSDSB_NSTAGE-1:0] stage_open_load,
	input wire logic [PSDSB_NSTAGE-1:0] stage_short_to_battery,
	// Bridge one events, same clock domain
	input wire logic bridge_overcurrent_on,
	input wire logic bridge_detect_running,
	// Mode and alarm
	input wire logic stage_bridge_select,
	input wire logic watchdog_alarm_pin,
	output logic irq
);

	// Stage order: 0..3 inj 1-4, 4..6 out 5-7, 7..8 out 13-14,
	// 9..12 out 15-18, 13 out 20, 14..17 out 21-24, 18..19 spare
	typedef struct packed {
		logic [PSDSB_NSTAGE-1:0][1:0] code;
		logic [7:0] bridge;
		logic [2:0] alarm_sync;
		logic alarm;
		logic [PSDSB_NREG-1:0] irq_status;
		logic [PSDSB_NREG-1:0] irq_mask;
		logic [7:0] rdata;
		logic irq;
	} psdsb_state_type;

	psdsb_state_type st_r;
	psdsb_state_type st_nxt;

	logic [7:0] view [PSDSB_NREG+1];
	logic [PSDSB_NSTAGE-1:0][1:0] ev_code;
	logic [PSDSB_NSTAGE-1:0] ev_any;
	logic [PSDSB_NREG-1:0] reg_event;
	logic [PSDSB_NSTAGE-1:0] stage_clr;

	////////////////////////////////////////////////////////////////////////
	// Per-stage event coding; worst fault wins when several arrive at once
	genvar gi;
	generate
		for (gi = 0; gi < PSDSB_NSTAGE; gi++) begin : g_ev
			always_comb begin
				ev_any[gi] = stage_short_to_ground[gi] |
					stage_open_load[gi] | stage_short_to_battery[gi];
				if (stage_short_to_ground[gi]) begin
					ev_code[gi] = PSDSB_CODE_SHORT_TO_GROUND;
				end else if (stage_short_to_battery[gi]) begin
					ev_code[gi] = PSDSB_CODE_SHORT_TO_BATTERY;
				end else if (stage_open_load[gi]) begin
					ev_code[gi] = PSDSB_CODE_OPEN_LOAD;
				end else begin
					ev_code[gi] = PSDSB_CODE_NO_FAULT;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Swap ground and battery meaning for outputs 21 and 23
	function automatic logic [1:0] psdsb_swap(input logic [1:0] c);
		if (c == PSDSB_CODE_SHORT_TO_GROUND) begin
			return PSDSB_CODE_SHORT_TO_BATTERY;
		end else if (c == PSDSB_CODE_SHORT_TO_BATTERY) begin
			return PSDSB_CODE_SHORT_TO_GROUND;
		end
		return c;
	endfunction

	// Stored value 00 means cleared; shown as no fault (11) on read
	function automatic logic [1:0] psdsb_show(input logic [1:0] c);
		return ~c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Read views of the register contents
	always_comb begin
		view[0] = {psdsb_show(st_r.code[3]), psdsb_show(st_r.code[2]),
			psdsb_show(st_r.code[1]), psdsb_show(st_r.code[0])};
		view[1] = {2'h0, psdsb_show(st_r.code[6]),
			psdsb_show(st_r.code[5]), psdsb_show(st_r.code[4])};
		view[2] = {psdsb_show(st_r.code[8]), psdsb_show(st_r.code[7]),
			st_r.alarm, 3'h0};
		view[3] = {psdsb_show(st_r.code[12]), psdsb_show(st_r.code[11]),
			psdsb_show(st_r.code[10]), psdsb_show(st_r.code[9])};
		view[4] = {PSDSB_REG5_RESERVED, psdsb_show(st_r.code[13]),
			2'h0};
		if (stage_bridge_select) begin
			view[5] = ~st_r.bridge;
		end else begin
			view[5] = {psdsb_show(st_r.code[17]),
				psdsb_swap(psdsb_show(st_r.code[16])),
				psdsb_show(st_r.code[15]),
				psdsb_swap(psdsb_show(st_r.code[14]))};
		end
		view[6] = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Which stages each register read clears
	always_comb begin
		stage_clr = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				PSDSB_INJECTOR_OUTPUTS_FAULT_STATUS: stage_clr[3:0] = '1;
				PSDSB_LOW_SIDE_OUTPUTS_FAULT_STATUS: stage_clr[6:4] = '1;
				PSDSB_RELAY_PAIR_AND_ALARM_STATUS: stage_clr[8:7] = '1;
				PSDSB_RELAY_OUTPUTS_FAULT_STATUS: stage_clr[12:9] = '1;
				PSDSB_SMALL_OUTPUT_FAULT_STATUS: stage_clr[13] = 1'b1;
				PSDSB_BRIDGE_ONE_FAULT_STATUS: stage_clr[17:14] = '1;
				default: stage_clr = '0;
			endcase
		end
	end

	// Events grouped per register for the interrupt status
	always_comb begin
		reg_event[0] = |ev_any[3:0];
		reg_event[1] = |ev_any[6:4];
		reg_event[2] = |ev_any[8:7];
		reg_event[3] = |ev_any[12:9];
		reg_event[4] = ev_any[13];
		reg_event[5] = (|ev_any[17:14]) | bridge_overcurrent_on |
			bridge_detect_running;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_nxt = st_r;
		// Alarm pin passes three flops; level changes once 2nd and 3rd agree
		st_nxt.alarm_sync = {st_r.alarm_sync[1:0], watchdog_alarm_pin};
		if (st_r.alarm_sync[2] == st_r.alarm_sync[1]) begin
			st_nxt.alarm = st_r.alarm_sync[2];
		end
		// Read clear first, then new events, so a coincident fault survives
		for (int i = 0; i < PSDSB_NSTAGE; i++) begin
			if (stage_clr[i]) begin
				st_nxt.code[i] = 2'h0;
			end
			if (ev_any[i]) begin
				st_nxt.code[i] = ~ev_code[i];
			end
		end
		if (reg_rd && reg_addr == PSDSB_BRIDGE_ONE_FAULT_STATUS) begin
			st_nxt.bridge = 8'h00;
		end
		if (bridge_detect_running) begin
			st_nxt.bridge = ~PSDSB_BR_DETECT_RUNNING;
		end
		if (bridge_overcurrent_on) begin
			st_nxt.bridge = ~PSDSB_BR_OVERCURRENT_ON;
		end
		// Read data, one cycle after the strobe; writes to status ignored
		st_nxt.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				PSDSB_INJECTOR_OUTPUTS_FAULT_STATUS: st_nxt.rdata = view[0];
				PSDSB_LOW_SIDE_OUTPUTS_FAULT_STATUS: st_nxt.rdata = view[1];
				PSDSB_RELAY_PAIR_AND_ALARM_STATUS: st_nxt.rdata = view[2];
				PSDSB_RELAY_OUTPUTS_FAULT_STATUS: st_nxt.rdata = view[3];
				PSDSB_SMALL_OUTPUT_FAULT_STATUS: st_nxt.rdata = view[4];
				PSDSB_BRIDGE_ONE_FAULT_STATUS: st_nxt.rdata = view[5];
				PSDSB_IRQ_STATUS: st_nxt.rdata = {2'h0, st_r.irq_status};
				PSDSB_IRQ_MASK: st_nxt.rdata = {2'h0, st_r.irq_mask};
				default: st_nxt.rdata = view[6];
			endcase
		end
		// Interrupt status: read clears, a new event wins over the clear
		if (reg_rd && reg_addr == PSDSB_IRQ_STATUS) begin
			st_nxt.irq_status = '0;
		end
		st_nxt.irq_status = st_nxt.irq_status | reg_event;
		if (reg_wr && reg_addr == PSDSB_IRQ_MASK) begin
			st_nxt.irq_mask = reg_wdata[PSDSB_NREG-1:0];
		end
		st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////
	// State register; all fields cleared at reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r.code <= '0;
			st_r.bridge <= PSDSB_REG_RESET;
			st_r.alarm_sync <= 3'h0;
			st_r.alarm <= 1'b0;
			st_r.irq_status <= '0;
			st_r.irq_mask <= PSDSB_MASK_RESET;
			st_r.rdata <= PSDSB_REG_RESET;
			st_r.irq <= 1'b0;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign irq = st_r.irq;

endmodule

/* design/psdsb_pkg.sv */
package psdsb_pkg;

	// Register subaddresses within the shared diagnostic read address
	localparam logic [7:0] PSDSB_INJECTOR_OUTPUTS_FAULT_STATUS = 8'h01;
	localparam logic [7:0] PSDSB_LOW_SIDE_OUTPUTS_FAULT_STATUS = 8'h02;
	localparam logic [7:0] PSDSB_RELAY_PAIR_AND_ALARM_STATUS = 8'h03;
	localparam logic [7:0] PSDSB_RELAY_OUTPUTS_FAULT_STATUS = 8'h04;
	localparam logic [7:0] PSDSB_SMALL_OUTPUT_FAULT_STATUS = 8'h05;
	localparam logic [7:0] PSDSB_BRIDGE_ONE_FAULT_STATUS = 8'h06;
	// Interrupt registers
	localparam logic [7:0] PSDSB_IRQ_STATUS = 8'h10;
	localparam logic [7:0] PSDSB_IRQ_MASK = 8'h11;

	// Register reset value
	localparam logic [7:0] PSDSB_REG_RESET = 8'h00;
	localparam logic [5:0] PSDSB_MASK_RESET = 6'h00;

	// 2-bit fault codes
	localparam logic [1:0] PSDSB_CODE_SHORT_TO_GROUND = 2'h0;
	localparam logic [1:0] PSDSB_CODE_OPEN_LOAD = 2'h1;
	localparam logic [1:0] PSDSB_CODE_SHORT_TO_BATTERY = 2'h2;
	localparam logic [1:0] PSDSB_CODE_NO_FAULT = 2'h3;

	// Bridge codes
	localparam logic [7:0] PSDSB_BR_OVERCURRENT_ON = 8'h03;
	localparam logic [7:0] PSDSB_BR_DETECT_RUNNING = 8'h07;
	localparam logic [7:0] PSDSB_BR_NO_FAULT = 8'hFF;

	// Fixed field positions
	localparam int PSDSB_ALARM_BIT = 3;
	localparam logic [3:0] PSDSB_REG5_RESERVED = 4'hF;

	// Stage count, stages indexed 0..NSTAGE-1, and count of fault status registers
	localparam int PSDSB_NSTAGE = 20;
	localparam int PSDSB_NREG = 6;

endpackage

/* dv/psdsb_bank_assertions.sv */
`timescale 1ns/1ns
module psdsb_chk
	import psdsb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [PSDSB_NSTAGE-1:0] stage_short_to_ground,
	input wire logic [PSDSB_NSTAGE-1:0] stage_open_load,
	input wire logic [PSDSB_NSTAGE-1:0] stage_short_to_battery,
	input wire logic bridge_overcurrent_on,
	input wire logic bridge_detect_running,
	input wire logic watchdog_alarm_pin
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Address of a read in flight; zero when idle, no register sits there
	wire [7:0] ra = reg_rd ? reg_addr : 8'h00;
	wire [7:0] q = reg_rdata;
	wire w = watchdog_alarm_pin;
	wire [19:0] ev = stage_short_to_ground | stage_open_load |
		stage_short_to_battery;
	// An event during the first read would show up in the second one
	wire c1 = ra == 8'h01 && ev[3:0] == 4'h0;
	wire c6 = ra == 8'h06 && ev[17:14] == 4'h0 && !bridge_overcurrent_on &&
		!bridge_detect_running;
	////////////////////////////////
	a_rdata_idle: assert property (!reg_rd |=> q == 8'h00)
		else $error("read data not idle");
	a_reg2_top: assert property (ra == 8'h02 |=> q[7:6] == 2'h0)
		else $error("reg 2 top bits set");
	a_reg3_low: assert property (ra == 8'h03 |=> q[2:0] == 3'h0)
		else $error("reg 3 low bits set");
	a_reg5_top: assert property (ra == 8'h05 |=> q[7:4] == 4'hF)
		else $error("reg 5 reserved bits not ones");
	a_reg5_low: assert property (ra == 8'h05 |=> q[1:0] == 2'h0)
		else $error("reg 5 low bits set");
	a_reg1_clear: assert property (c1 [*2] |=> q == 8'hFF)
		else $error("reg 1 not cleared by read");
	a_reg6_clear: assert property (c6 [*2] |=> q == 8'hFF)
		else $error("reg 6 not cleared by read");
	a_alarm_live: assert property ($stable(w) [*6] ##0 ra == 8'h03
		|=> q[3] == $past(w)) else $error("alarm bit not live");
	c_bridge: cover property (ra == 8'h06 ##1 q == 8'h07);
	c_swap: cover property (ra == 8'h06 ##1 q[1:0] == 2'h0);
	c_irq: cover property (ra == 8'h10 ##1 q != 8'h00);
endmodule
bind psdsb_bank psdsb_chk chk (.*);

/* dv/psdsb_host.sv */
`timescale 1ns/1ns
// Host on the register port; it never waits, the slave answers in one cycle
module psdsb_host (
	input wire logic sys_clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
	////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Two reads back to back; each answer stands only one cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d0, d1);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		#1 d0 = reg_rdata;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d1 = reg_rdata;
	endtask
endmodule

/* dv/test_power_stage_diag_status_bank.sv */
`timescale 1ns/1ns
module test_power_stage_diag_status_bank;
	logic sys_clk = 0, rst_n = 0, stage_bridge_select = 0;
	logic watchdog_alarm_pin = 0, bridge_overcurrent_on = 0;
	logic bridge_detect_running = 0, reg_wr, reg_rd, irq;
	logic [19:0] stage_short_to_ground = '0, stage_open_load = '0;
	logic [19:0] stage_short_to_battery = '0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d0, d1, br = 8'hFF;
	logic [1:0] f[20] = '{default: 2'h3};
	logic [5:0] st = '0, msk = '0, st0;
	logic [1:0] f0;
	logic clk_en = 1'b1;
	int error_cnt = 0, tests_run = 0;
	int tbl[9] = '{1, 2, 3, 4, 5, 6, 16, 17, 32};
	psdsb_host u_host (.*);
	psdsb_bank uut (.*);
	// Clock, and a watchdog in case the run hangs
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		#2000000;
		error_cnt++;
		stop_test();
	end
	////////////////////////////////
	task automatic stop_test();
		if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask
	// Register of a stage input; inputs 18 and 19 are never pulsed
	function automatic int rof(input int i);
		return i < 4 ? 1 : i < 7 ? 2 : i < 9 ? 3 : i < 13 ? 4 : i < 14 ? 5 : 6;
	endfunction
	// Outputs 21 and 23 swap the battery and ground codes
	function automatic logic [1:0] sw(input logic [1:0] x);
		return {x[1] ^ ~x[0], x[0]};
	endfunction
	function automatic logic [7:0] view(input int r);
		case (r)
			1: return {f[3], f[2], f[1], f[0]};
			2: return {2'h0, f[6], f[5], f[4]};
			3: return {f[8], f[7], watchdog_alarm_pin, 3'h0};
			4: return {f[12], f[11], f[10], f[9]};
			5: return {4'hF, f[13], 2'h0};
			6: return stage_bridge_select ? br :
				{f[17], sw(f[16]), f[15], sw(f[14])};
			16: return {2'h0, st};
			17: return {2'h0, msk};
			default: return 8'h00;
		endcase
	endfunction
	// One-cycle event: kinds 0-2 hit a stage, 3 and 4 the bridge
	task automatic ev(input int s, input int k);
		@(posedge sys_clk);
		stage_short_to_ground[s] <= k == 0;
		stage_open_load[s] <= k == 1;
		stage_short_to_battery[s] <= k == 2;
		bridge_overcurrent_on <= k == 3;
		bridge_detect_running <= k == 4;
		@(posedge sys_clk);
		{stage_short_to_ground, stage_open_load, stage_short_to_battery} <= '0;
		{bridge_overcurrent_on, bridge_detect_running} <= 2'h0;
		if (k < 3) f[s] = 2'(k);
		else br = k == 3 ? 8'h03 : 8'h07;
		st[k < 3 ? rof(s) - 1 : 5] = 1'b1;
	endtask
	// Settle the alarm sync, check the interrupt, then read twice
	task automatic rchk(input int r);
		@(posedge sys_clk);
		watchdog_alarm_pin <= 1'($urandom);
		repeat (6) @(posedge sys_clk);
		chk({7'h00, irq}, {7'h00, |(st & msk)});
		u_host.rd(8'(r), d0, d1);
		chk(d0, view(r));
		for (int i = 0; i < 20; i++)
			if (rof(i) == r) f[i] = 2'h3;
		if (r == 6) br = 8'hFF;
		if (r == 16) st = '0;
		chk(d1, view(r));
	endtask
	////////////////////////////////
	initial begin
		void'($urandom(32'h95B0));
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 9; i++) rchk(tbl[i]);
		for (int n = 0; n < 150; n++) begin
			ev($urandom % 18, $urandom % 5);
			if (n % 3 == 2) rchk(tbl[$urandom % 9]);
			if (n % 8 == 7) begin
				@(posedge sys_clk);
				stage_bridge_select <= ~stage_bridge_select;
				msk = 6'($urandom);
				u_host.wr(8'h11, {2'h0, msk});
				u_host.wr(8'($urandom % 7), 8'h00);
			end
		end
		// Enable low freezes capture: the pulse must leave no trace
		f0 = f[0];
		st0 = st;
		@(posedge sys_clk);
		clk_en <= 1'b0;
		ev(0, 0);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		f[0] = f0;
		st = st0;
		rchk(1);
		rchk(16);
		stop_test();
	end
endmodule
